// >>> pkg/usf_consts.svh
// Purpose: Constants of the serial status-flag block
// Assumes: 32-bit Avalon-MM word registers
// Notes: Offsets are byte addresses
`ifndef USF_CONSTS_SVH
`define USF_CONSTS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define USF_ADDR_W 4
`define USF_OFF_STATUS 4'h0
`define USF_OFF_DATA 4'h4
`define USF_OFF_CTRL1 4'h8
`define USF_OFF_CTRL2 4'hC
// ----------------------------------------
// Status bit positions and reset
// ----------------------------------------
`define USF_B_TXE 7
`define USF_B_TXD 6
`define USF_B_RXR 5
`define USF_B_IDLE 4
`define USF_B_OVR 3
`define USF_B_NOISE 2
`define USF_B_FRM 1
`define USF_B_PAR 0
`define USF_STATUS_RST 8'hC0
// ----------------------------------------
// Control bit positions
// ----------------------------------------
`define USF_C1_PCE 2
`define USF_C1_PS 1
`define USF_C1_PIE 0
`define USF_C2_TIE 7
`define USF_C2_TX_DONE_IRQ_EN 6
`define USF_C2_RIE 5
`define USF_C2_IDLE_IRQ_EN 4
// Majority samples within the 16 per bit
`define USF_SMP_A 4'h7
`define USF_SMP_B 4'h8
`define USF_SMP_C 4'h9
`endif

// >>> pkg/usf_pkg.sv
// Purpose: Types of the serial status-flag block
// Assumes: Included constants header
// Notes: None
package usf_pkg;
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } usf_bus_req_s;

  typedef struct packed {
    logic        tx_load;
    logic        tx_frame_done;
    logic        tx_frame_is_data;
    logic        rx_word_valid;
    logic [7:0]  rx_word;
    logic        rx_parity_bit;
    logic        rx_frame_fault;
    logic        rx_idle_line;
  } usf_evt_s;

  typedef enum logic [0:0] {USF_SEQ_IDLE, USF_SEQ_ARMED} usf_seq_e;

  typedef struct packed {
    logic [1:0]  rst_sync;
    logic [7:0]  status;
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic [7:0]  data_rx;
    logic [7:0]  hold_rx;
    logic        hold_full;
    logic        hold_noise;
    logic        hold_frm;
    logic        hold_par;
    logic [7:0]  tx_hold;
    logic        idle_armed;
    usf_seq_e    seq;
    logic        rvalid;
    logic [31:0] rdata;
    logic [3:0]  smp_cnt;
    logic [2:0]  smp;
    logic        bit_noise;
    logic        noise_acc;
  } usf_state_s;
endpackage

// >>> rtl/usf_status_flags.sv
// Purpose: Status flags, interrupt request and clear sequences of a serial port
// Assumes: Shifters and baud logic outside; events are one-cycle pulses
// Notes: Registers on Avalon-MM, one word each, waitrequest used for reads
//
// How it works
// - Set tx empty when holding buffer loads shifter
// - Tx empty with enable requests interrupt
// - Tx flags clear on status access, data write
// - Set tx done after data frame shifts out
// - Idle or break frame leaves tx done
// - Tx done with enable requests interrupt
// - Set rx ready when word reaches data register
// - Rx ready or overrun with enable interrupts
// - Rx flags clear on status access, data read
// - Set idle flag on idle line
// - Idle with enable requests interrupt
// - Idle re-arms only after rx ready sets
// - Overrun when new word meets rx ready
// - Overrun keeps holding buffer, shifter overwritten
// - Set noise flag on noisy frame
// - Framing flag on desync, noise or break
// - Noise and framing have no own interrupt
// - Framing plus overrun sets only overrun
// - Parity fault on failed check when enabled
// - Parity clears on status read, data access
// - Parity fault with enable requests interrupt
// - Status resets to C0, all read-only
// - Even or odd count by parity select
// - Majority of samples 8-10, disagreement is noise
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "usf_consts.svh"

module usf_status_flags
  import usf_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_address,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_sample_tick,
  input wire logic rx_sample_in,
  input wire logic rx_bit_start,
  input wire logic tx_load,
  input wire logic tx_frame_done,
  input wire logic tx_frame_is_data,
  input wire logic rx_word_valid,
  input wire logic [7:0] rx_word,
  input wire logic rx_parity_bit,
  input wire logic rx_frame_fault,
  input wire logic rx_idle_line,
  output logic [7:0] tx_word,
  output logic parity_enable,
  output logic parity_select,
  output logic uart_irq
);

  // Elaboration-time refusal of widths the flag logic cannot serve
  if (DATA_W != 8) begin : g_bad_width
    $error("usf_status_flags supports DATA_W of 8 only");
  end

  usf_state_s s_r;
  usf_state_s s_nxt;
  usf_bus_req_s req;
  usf_evt_s evt;

  assign req = '{read: avs_read, write: avs_write, address: avs_address, writedata: avs_writedata};
  assign evt = '{tx_load: tx_load, tx_frame_done: tx_frame_done, tx_frame_is_data: tx_frame_is_data,
                 rx_word_valid: rx_word_valid, rx_word: rx_word, rx_parity_bit: rx_parity_bit,
                 rx_frame_fault: rx_frame_fault, rx_idle_line: rx_idle_line};

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic hit(input usf_bus_req_s r, input logic [3:0] off);
    hit = r.address == off;
  endfunction

  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
  endfunction

  // Reset release through two flops; async assert only loads constants
  logic rst_n_sync;
  logic [1:0] rst_pipe_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe_r <= 2'h0;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_pipe_r[1];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic st_acc;
  logic dat_rd;
  logic dat_wr;
  logic seq_hit;
  logic par_ok;
  logic overrun;
  logic word_noise;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rst_sync = 2'h0;
    st_acc = (req.read | req.write) & hit(req, `USF_OFF_STATUS);
    dat_rd = req.read & hit(req, `USF_OFF_DATA) & s_r.rvalid;
    dat_wr = req.write & hit(req, `USF_OFF_DATA);
    seq_hit = s_r.seq == USF_SEQ_ARMED;
    // Even total needed when select low, odd when high
    par_ok = (^{evt.rx_word, evt.rx_parity_bit}) == s_r.ctrl1[`USF_C1_PS];
    // Any new word while the data register is unread overruns
    overrun = evt.rx_word_valid & s_r.status[`USF_B_RXR];
    word_noise = s_r.noise_acc | s_r.bit_noise;

    // Bit sampling: majority of samples 8..10, disagreement marks noise
    if (rx_bit_start) begin
      s_nxt.smp_cnt = 4'h0;
      s_nxt.bit_noise = 1'b0;
    end else if (rx_sample_tick) begin
      s_nxt.smp_cnt = s_r.smp_cnt + 4'h1;
      if (s_r.smp_cnt == `USF_SMP_A || s_r.smp_cnt == `USF_SMP_B || s_r.smp_cnt == `USF_SMP_C) begin
        s_nxt.smp = {s_r.smp[1:0], rx_sample_in};
      end
      if (s_r.smp_cnt == `USF_SMP_C) begin
        s_nxt.bit_noise = ({s_r.smp[1:0], rx_sample_in} != {3{maj3({s_r.smp[1:0], rx_sample_in})}});
        s_nxt.noise_acc = s_r.noise_acc | s_nxt.bit_noise;
      end
    end

    // Bus: writes complete at once, reads take one wait cycle
    s_nxt.rvalid = 1'b0;
    if (req.read && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      case (req.address)
        `USF_OFF_STATUS: s_nxt.rdata = {24'h0, s_r.status};
        `USF_OFF_DATA: s_nxt.rdata = {24'h0, s_r.data_rx};
        `USF_OFF_CTRL1: s_nxt.rdata = {24'h0, s_r.ctrl1};
        `USF_OFF_CTRL2: s_nxt.rdata = {24'h0, s_r.ctrl2};
        default: s_nxt.rdata = 32'h0;
      endcase
    end
    if (req.write) begin
      case (req.address)
        `USF_OFF_CTRL1: s_nxt.ctrl1 = req.writedata[7:0];
        `USF_OFF_CTRL2: s_nxt.ctrl2 = req.writedata[7:0];
        `USF_OFF_DATA: s_nxt.tx_hold = req.writedata[7:0];
        default: ; // Status is read-only; writes ignored
      endcase
    end

    // Sequence tracker: status access arms, data access consumes
    if (st_acc && (!req.read || !s_r.rvalid)) begin
      s_nxt.seq = USF_SEQ_ARMED;
    end else if (dat_wr || dat_rd) begin
      s_nxt.seq = USF_SEQ_IDLE;
    end

    // Clears first, so a same-cycle set below wins
    if (seq_hit && dat_wr) begin
      s_nxt.status[`USF_B_TXE] = 1'b0;
      s_nxt.status[`USF_B_TXD] = 1'b0;
    end
    if (seq_hit && dat_rd) begin
      s_nxt.status[`USF_B_RXR] = 1'b0;
      s_nxt.status[`USF_B_IDLE] = 1'b0;
      s_nxt.status[`USF_B_OVR] = 1'b0;
      s_nxt.status[`USF_B_NOISE] = 1'b0;
      s_nxt.status[`USF_B_FRM] = 1'b0;
    end
    if (seq_hit && (dat_rd || dat_wr)) begin
      s_nxt.status[`USF_B_PAR] = 1'b0;
    end

    // Transmit events
    if (evt.tx_load) begin
      s_nxt.status[`USF_B_TXE] = 1'b1;
    end
    if (evt.tx_frame_done && evt.tx_frame_is_data) begin
      s_nxt.status[`USF_B_TXD] = 1'b1;
    end

    // Receive word into the holding buffer
    if (evt.rx_word_valid) begin
      s_nxt.noise_acc = 1'b0;
      if (overrun) begin
        s_nxt.status[`USF_B_OVR] = 1'b1;
      end else begin
        // Holding buffer kept on overrun; the new word is dropped
        s_nxt.hold_rx = evt.rx_word;
        s_nxt.hold_full = 1'b1;
        s_nxt.hold_noise = word_noise;
        s_nxt.hold_frm = evt.rx_frame_fault;
        s_nxt.hold_par = s_r.ctrl1[`USF_C1_PCE] & ~par_ok;
      end
    end

    // Move holding buffer to data register when software has taken the last
    if (s_r.hold_full && !s_r.status[`USF_B_RXR]) begin
      s_nxt.data_rx = s_r.hold_rx;
      s_nxt.hold_full = 1'b0;
      s_nxt.status[`USF_B_RXR] = 1'b1;
      s_nxt.idle_armed = 1'b1;
      if (s_r.hold_noise) begin
        s_nxt.status[`USF_B_NOISE] = 1'b1;
      end
      if (s_r.hold_frm) begin
        s_nxt.status[`USF_B_FRM] = 1'b1;
      end
      if (s_r.hold_par) begin
        s_nxt.status[`USF_B_PAR] = 1'b1;
      end
    end

    // One idle event per received word; re-armed when rx ready sets
    if (evt.rx_idle_line && s_r.idle_armed) begin
      s_nxt.status[`USF_B_IDLE] = 1'b1;
      s_nxt.idle_armed = 1'b0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      s_r <= '0;
      s_r.status <= `USF_STATUS_RST;
      s_r.seq <= USF_SEQ_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = avs_read & ~s_r.rvalid;
  assign tx_word = s_r.tx_hold;
  assign parity_enable = s_r.ctrl1[`USF_C1_PCE];
  assign parity_select = s_r.ctrl1[`USF_C1_PS];
  // Noise and framing deliberately absent; they ride on rx ready
  assign uart_irq = (s_r.status[`USF_B_TXE] & s_r.ctrl2[`USF_C2_TIE])
                  | (s_r.status[`USF_B_TXD] & s_r.ctrl2[`USF_C2_TX_DONE_IRQ_EN])
                  | ((s_r.status[`USF_B_RXR] | s_r.status[`USF_B_OVR]) & s_r.ctrl2[`USF_C2_RIE])
                  | (s_r.status[`USF_B_IDLE] & s_r.ctrl2[`USF_C2_IDLE_IRQ_EN])
                  | (s_r.status[`USF_B_PAR] & s_r.ctrl1[`USF_C1_PIE]);

endmodule

// >>> tb/usf_status_flags_sva.sv
// Purpose: Port-level checks of the status-flag block
// Assumes: Control bits shadowed from bus writes
// Notes: Status itself is not a port, so flags show through the irq
`timescale 1ns/1ps
module usf_status_flags_sva
  import usf_pkg::*;
(
  input wire logic clk, reset_n, avs_read, avs_write, avs_waitrequest,
  input wire logic [3:0] avs_address,
  input wire logic [31:0] avs_writedata,
  input wire logic tx_load, tx_frame_done, tx_frame_is_data, rx_word_valid,
  input wire logic [7:0] rx_word,
  input wire logic rx_parity_bit, parity_enable, parity_select, uart_irq
);
  logic [7:0] c1_r;
  logic [7:0] c2_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      c1_r <= 8'h00;
      c2_r <= 8'h00;
    end else if (avs_write) begin
      if (avs_address == 4'h8) c1_r <= avs_writedata[7:0];
      if (avs_address == 4'hC) c2_r <= avs_writedata[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_par_fail; rx_word_valid && parity_enable && (^{rx_word, rx_parity_bit} != parity_select); endsequence
  property p_txe_irq; tx_load && c2_r[7] |=> uart_irq; endproperty
  a_txe_irq: assert property (p_txe_irq) else $error("tx empty irq missing");
  property p_txd_irq; tx_frame_done && tx_frame_is_data && c2_r[6] |=> uart_irq; endproperty
  a_txd_irq: assert property (p_txd_irq) else $error("tx done irq missing");
  property p_rx_irq; rx_word_valid && c2_r[5] |-> ##2 uart_irq; endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx irq missing");
  property p_par_irq; s_par_fail ##0 c1_r[0] |-> ##[1:2] uart_irq; endproperty
  a_par_irq: assert property (p_par_irq) else $error("parity irq missing");
  property p_no_en; c1_r[0] == 1'b0 && c2_r[7:4] == 4'h0 |-> !uart_irq; endproperty
  a_no_en: assert property (p_no_en) else $error("irq without enable");
  property p_rst_quiet; $rose(reset_n) |-> !uart_irq [*2]; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("irq after reset");
  property p_rd_ans; avs_read && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_wr_nowait; avs_write |-> !avs_waitrequest; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
endmodule
bind usf_status_flags usf_status_flags_sva u_sva (
  .clk(clk), .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .avs_address(avs_address), .avs_writedata(avs_writedata),
  .tx_load(tx_load), .tx_frame_done(tx_frame_done), .tx_frame_is_data(tx_frame_is_data),
  .rx_word_valid(rx_word_valid), .rx_word(rx_word), .rx_parity_bit(rx_parity_bit),
  .parity_enable(parity_enable), .parity_select(parity_select), .uart_irq(uart_irq)
);

// >>> tb/usf_line_model.sv
// Purpose: Far-side receiver events for the status-flag block
// Assumes: Line idles high; one sampled bit stands for a frame
// Notes: Released word lines show the inverse of the last value
`timescale 1ns/1ps
module usf_line_model (
  input wire logic clk,
  output logic rx_sample_tick, rx_sample_in, rx_bit_start, rx_word_valid,
  output logic [7:0] rx_word,
  output logic rx_parity_bit, rx_frame_fault, rx_idle_line
);
  initial begin
    {rx_sample_tick, rx_bit_start, rx_word_valid, rx_idle_line} = 4'h0;
    {rx_sample_in, rx_word, rx_parity_bit, rx_frame_fault} = 11'h400;
  end
  task automatic send(input logic [7:0] d, input logic p, input logic f, input logic n);
    rx_bit_start <= 1'b1;
    @(posedge clk);
    rx_bit_start <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      rx_sample_tick <= 1'b1;
      rx_sample_in <= !(n && i == 8);
      @(posedge clk);
    end
    {rx_sample_tick, rx_sample_in} <= 2'b01;
    {rx_word_valid, rx_word, rx_parity_bit, rx_frame_fault} <= {1'b1, d, p, f};
    @(posedge clk);
    {rx_word_valid, rx_word, rx_parity_bit, rx_frame_fault} <= {1'b0, ~d, ~p, ~f};
    repeat (3) @(posedge clk);
  endtask
  task automatic idle();
    rx_idle_line <= 1'b1;
    @(posedge clk);
    rx_idle_line <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// >>> tb/tb_usf_status_flags.sv
// Purpose: Self-checking bench of the status-flag block
// Assumes: Line model drives the receive events
// Notes: Every status read also arms the clear sequence
`timescale 1ns/1ps
module tb_usf_status_flags;
  logic clk, reset_n, avs_read, avs_write, avs_waitrequest, tx_load, tx_frame_done, tx_frame_is_data;
  logic rx_sample_tick, rx_sample_in, rx_bit_start, rx_word_valid, rx_parity_bit, rx_frame_fault;
  logic rx_idle_line, parity_enable, parity_select, uart_irq;
  logic [3:0] avs_address;
  logic [7:0] rx_word, tx_word;
  logic [31:0] avs_writedata, avs_readdata, v;
  int num_errors = 0;
  int compares = 0;
  usf_status_flags dut (.clk(clk), .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_address(avs_address), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_sample_tick(rx_sample_tick), .rx_sample_in(rx_sample_in),
    .rx_bit_start(rx_bit_start), .tx_load(tx_load), .tx_frame_done(tx_frame_done),
    .tx_frame_is_data(tx_frame_is_data), .rx_word_valid(rx_word_valid), .rx_word(rx_word),
    .rx_parity_bit(rx_parity_bit), .rx_frame_fault(rx_frame_fault), .rx_idle_line(rx_idle_line),
    .tx_word(tx_word), .parity_enable(parity_enable), .parity_select(parity_select), .uart_irq(uart_irq));
  usf_line_model far_end (.clk(clk), .rx_sample_tick(rx_sample_tick), .rx_sample_in(rx_sample_in),
    .rx_bit_start(rx_bit_start), .rx_word_valid(rx_word_valid), .rx_word(rx_word),
    .rx_parity_bit(rx_parity_bit), .rx_frame_fault(rx_frame_fault), .rx_idle_line(rx_idle_line));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    {avs_write, avs_address, avs_writedata} <= {1'b1, a, 24'h000000, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  // Bus answer waits: one cycle for reads, none for writes; the watchdog bounds them
  task automatic rd(input logic [3:0] a);
    {avs_read, avs_address} <= {1'b1, a};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    v = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic st(input logic [7:0] e);
    rd(4'h0);
    chk("status", {24'h000000, e}, v);
  endtask
  task automatic irq_is(input logic e);
    chk("irq", {31'h0, e}, {31'h0, uart_irq});
  endtask
  task automatic tx_evt(input logic l, input logic d, input logic i);
    {tx_load, tx_frame_done, tx_frame_is_data} <= {l, d, i};
    @(posedge clk);
    {tx_load, tx_frame_done, tx_frame_is_data} <= {2'b00, ~i};
    @(posedge clk);
  endtask
  task automatic t_reset();
    st(8'hC0);
    irq_is(1'b0);
    wr(4'h0, 8'h00);
    st(8'hC0);
    rd(4'h2);
    chk("unmapped", 32'h0, v);
    $display("test reset done");
  endtask
  task automatic t_tx();
    wr(4'hC, 8'h80);
    irq_is(1'b1);
    wr(4'h4, 8'h5A);
    irq_is(1'b0);
    tx_evt(1'b1, 1'b0, 1'b0);
    wr(4'h4, 8'hA5);
    chk("tx_word", 32'hA5, {24'h0, tx_word});
    st(8'h80);
    irq_is(1'b1);
    wr(4'h4, 8'h00);
    tx_evt(1'b0, 1'b1, 1'b0);
    st(8'h00);
    wr(4'hC, 8'h40);
    tx_evt(1'b0, 1'b1, 1'b1);
    st(8'h40);
    irq_is(1'b1);
    wr(4'h4, 8'h00);
    $display("test tx done");
  endtask
  task automatic t_rx();
    wr(4'hC, 8'h20);
    far_end.send(8'h3C, 1'b0, 1'b0, 1'b0);
    st(8'h20);
    irq_is(1'b1);
    far_end.send(8'h96, 1'b0, 1'b0, 1'b0);
    far_end.send(8'h0F, 1'b0, 1'b1, 1'b0);
    st(8'h28);
    rd(4'h4);
    chk("data", 32'h3C, v);
    st(8'h00);
    far_end.send(8'h96, 1'b0, 1'b0, 1'b0);
    st(8'h20);
    rd(4'h4);
    chk("data", 32'h96, v);
    st(8'h00);
    irq_is(1'b0);
    $display("test rx done");
  endtask
  task automatic t_err();
    wr(4'hC, 8'h00);
    wr(4'h8, 8'h05);
    far_end.send(8'h35, 1'b1, 1'b0, 1'b1);
    st(8'h25);
    irq_is(1'b1);
    rd(4'h4);
    st(8'h00);
    wr(4'h8, 8'h07);
    far_end.send(8'h35, 1'b1, 1'b0, 1'b0);
    st(8'h20);
    irq_is(1'b0);
    rd(4'h4);
    wr(4'h8, 8'h00);
    far_end.send(8'h11, 1'b0, 1'b1, 1'b0);
    st(8'h22);
    irq_is(1'b0);
    rd(4'h4);
    $display("test errors done");
  endtask
  task automatic t_idle();
    wr(4'hC, 8'h10);
    far_end.send(8'h42, 1'b0, 1'b0, 1'b0);
    far_end.idle();
    st(8'h30);
    irq_is(1'b1);
    rd(4'h4);
    far_end.idle();
    st(8'h00);
    irq_is(1'b0);
    $display("test idle done");
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    {reset_n, avs_read, avs_write, tx_load, tx_frame_done, tx_frame_is_data} = 6'h00;
    {avs_address, avs_writedata} = 36'h0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_tx();
    t_rx();
    t_err();
    t_idle();
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
endmodule
